/* src/asc_pkg.sv */
`default_nettype none
package asc_pkg;
    localparam int NSEQ = 4;
    localparam int SEQ_DEPTH [NSEQ] = '{8, 4, 4, 1};
    localparam int MEM_BASE [NSEQ] = '{0, 8, 12, 16};
    localparam int MEM_WORDS = 17;
    localparam int MEM_AW = 5;
    localparam int RES_W = 10;
    localparam logic [31:0] STEP_MASK [NSEQ] = '{32'hffffffff, 32'h0000ffff, 32'h0000ffff,
        32'h0000000f};
    // Register byte offsets.
    localparam logic [11:0] OFF_ACT = 12'h000;
    localparam logic [11:0] OFF_RIS = 12'h004;
    localparam logic [11:0] OFF_IM = 12'h008;
    localparam logic [11:0] OFF_ISC = 12'h00c;
    localparam logic [11:0] OFF_OSTAT = 12'h010;
    localparam logic [11:0] OFF_EMUX = 12'h014;
    localparam logic [11:0] OFF_USTAT = 12'h018;
    localparam logic [11:0] OFF_PRI = 12'h020;
    localparam logic [11:0] OFF_PSSI = 12'h028;
    localparam logic [11:0] OFF_SAC = 12'h030;
    localparam logic [11:0] OFF_TMLB = 12'h100;
    // Per-sequencer block: index field addr[7:5] runs from SEQ_FIRST upward.
    localparam logic [2:0] SEQ_FIRST = 3'h2;
    localparam logic [4:0] SUB_MUX = 5'h00;
    localparam logic [4:0] SUB_CTL = 5'h04;
    localparam logic [4:0] SUB_FIFO = 5'h08;
    localparam logic [4:0] SUB_FSTAT = 5'h0c;
    // Reset values.
    localparam logic [31:0] RST_PRI = 32'h00003210;
    localparam logic [31:0] RST_CTL3 = 32'h00000002;
    // Step-control nibble flags.
    localparam int CTL_DIFF = 0;
    localparam int CTL_END = 1;
    localparam int CTL_IE = 2;
    localparam int CTL_TS = 3;
    // Trigger source codes.
    localparam logic [3:0] TRIG_PROC = 4'h0;
    localparam logic [3:0] TRIG_ALWAYS = 4'hf;
    localparam logic [2:0] SAC_MAX = 3'h6;
    localparam logic [9:0] DIFF_MID = 10'h1ff;
    localparam logic [9:0] CODE_MAX = 10'h3ff;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_START = 2'b01,
        ST_WAIT = 2'b10,
        ST_STORE = 2'b11
    } asc_state_t;
endpackage
`default_nettype wire

/* src/asc_result_mem.sv */
`default_nettype none
// Shared result storage for all FIFOs; the read register doubles as bus read data.
module asc_result_mem #(
    parameter int WORDS = 17,
    parameter int AW = 5,
    parameter int DW = 10
) (
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_rst_n,
    // Write port
    input wire logic i_wr_en,
    input wire logic [AW-1:0] i_wr_addr,
    input wire logic [DW-1:0] i_wr_data,
    // Read port
    input wire logic i_rd_en,
    input wire logic [AW-1:0] i_rd_addr,
    input wire logic [31:0] i_alt_data,
    output logic [31:0] o_q
);
    logic [DW-1:0] mem [WORDS];

    always_ff @(posedge i_mclk) begin
        if (i_wr_en) begin
            mem[i_wr_addr] <= i_wr_data;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            o_q <= 32'h0;
        end else if (i_rd_en) begin
            o_q <= {{(32-DW){1'b0}}, mem[i_rd_addr]};
        end else begin
            o_q <= i_alt_data;
        end
    end
endmodule
`default_nettype wire

/* src/asc_sequencer_ctl.sv */
// Added by the designer: the register offsets and strobed register access.
`default_nettype none
// Contract
// - Four sequencers, depths eight, four, four, one.
// - FIFO word is 32 bits, result low ten.
// - Each step has input and control nibble.
// - Control nibble: temp, irq enable, end, diff.
// - Sequencer runs only while its enable set.
// - Flagged steps raise raw interrupt on completion.
// - End flag stops sequence after that step.
// - FIFO circular; read pops oldest entry.
// - Pointers, full, empty, overflow, underflow visible.
// - Interrupt output is raw status masked.
// - Masked status shows only enabled interrupts.
// - Writing one to masked status clears interrupt.
// - Concurrent triggers served by priority, zero first.
// - Event select picks trigger, incl processor, always.
// - Processor initiate write triggers processor-sourced sequencers.
// - Averaging accumulates up to 64 samples.
// - Averaging off after reset, shared by all.
// - Single-ended codes 0x000 to 0x3FF unsigned.
// - Differential select names pair, even positive.
// - Differential result offset about 0x1FF.
// - Reset priority equals sequencer number.
module asc_sequencer_ctl #(
    parameter int NUM_EXT = 4
) (
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_rst_n,
    // Register port
    input wire logic [11:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata,
    // Peripheral triggers
    input wire logic [NUM_EXT-1:0] i_ext_trig,
    // Converter
    output logic o_conv_start,
    output logic [3:0] o_conv_sel,
    output logic o_conv_diff,
    output logic o_conv_temp,
    input wire logic i_conv_done,
    input wire logic [10:0] i_conv_data,
    // Interrupts
    output logic [3:0] o_irq
);
    localparam int N = asc_pkg::NSEQ;

    asc_pkg::asc_state_t state;
    logic [N-1:0] act, ris, im, ostat, ustat, pend;
    logic [15:0] emux;
    logic [7:0] pri;
    logic [2:0] sac;
    logic lb;
    logic [31:0] mux_r [N];
    logic [31:0] ctl_r [N];
    logic [2:0] wp [N];
    logic [2:0] rp [N];
    logic [3:0] cnt [N];
    logic [N-1:0] full, empty, trig, pop, set_ris;
    logic [1:0] cur, gnt, idx;
    logic [2:0] step;
    logic [6:0] avg_cnt;
    logic [15:0] acc, next_acc;
    logic [9:0] res, sample;
    logic gnt_ok, seq_hit, fifo_rd, push, last_step, avg_last, conv_ok, seq_done;
    logic [4:0] sub;
    logic [3:0] cur_in, cur_ctl;
    logic [31:0] rd_alt;
    logic [N-1:0] beats;
    logic signed [10:0] dhalf;
    logic signed [11:0] dsum;

    // Address decode for the per-sequencer register blocks.
    always_comb begin
        seq_hit = (i_addr[11:8] == 4'h0) && (i_addr[7:5] >= asc_pkg::SEQ_FIRST)
            && (i_addr[7:5] < asc_pkg::SEQ_FIRST + 3'(N));
        idx = 2'(i_addr[7:5] - asc_pkg::SEQ_FIRST);
        sub = i_addr[4:0];
        fifo_rd = i_rd && seq_hit && (sub == asc_pkg::SUB_FIFO);
    end

    // Current step nibbles.
    always_comb begin
        cur_in = mux_r[cur][{step, 2'b00} +: 4];
        cur_ctl = ctl_r[cur][{step, 2'b00} +: 4];
        last_step = (step == 3'(asc_pkg::SEQ_DEPTH[cur] - 1));
        conv_ok = lb || i_conv_done;
        seq_done = (state == asc_pkg::ST_STORE)
            && (cur_ctl[asc_pkg::CTL_END] || last_step);
        push = (state == asc_pkg::ST_STORE) && act[cur];
    end

    // Result formatting: differential offset about mid code, clipped.
    always_comb begin
        dhalf = $signed(i_conv_data) >>> 1;
        dsum = $signed({2'b00, asc_pkg::DIFF_MID}) + $signed({dhalf[10], dhalf});
        if (lb) begin
            sample = {6'h0, cur_in};
        end else if (cur_ctl[asc_pkg::CTL_DIFF]) begin
            if (dsum[11]) begin
                sample = 10'h0;
            end else if (dsum[10]) begin
                sample = asc_pkg::CODE_MAX;
            end else begin
                sample = dsum[9:0];
            end
        end else begin
            sample = i_conv_data[9:0];
        end
        next_acc = acc + {6'h0, sample};
        avg_last = (avg_cnt == ((7'h1 << sac) - 7'h1));
    end

    // Trigger selection per sequencer.
    always_comb begin
        for (int s = 0; s < N; s++) begin
            if (emux[4*s +: 4] == asc_pkg::TRIG_PROC) begin
                trig[s] = i_wr && (i_addr == asc_pkg::OFF_PSSI) && i_wdata[s];
            end else if (emux[4*s +: 4] == asc_pkg::TRIG_ALWAYS) begin
                trig[s] = 1'b1;
            end else if (int'(emux[4*s +: 4]) <= NUM_EXT) begin
                trig[s] = i_ext_trig[int'(emux[4*s +: 4]) - 1];
            end else begin
                trig[s] = 1'b0;
            end
        end
    end

    // Priority arbitration among pending enabled sequencers.
    always_comb begin
        gnt_ok = 1'b0;
        gnt = 2'h0;
        for (int p = 0; p < 4; p++) begin
            for (int s = 0; s < N; s++) begin
                if (!gnt_ok && pend[s] && act[s] && pri[2*s +: 2] == 2'(p)) begin
                    gnt_ok = 1'b1;
                    gnt = 2'(s);
                end
            end
        end
        for (int s = 0; s < N; s++) begin
            beats[s] = pend[s] && act[s] && (pri[2*s +: 2] < pri[2*gnt +: 2]);
        end
    end

    // Pending triggers: a new trigger wins over completion.
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            pend <= '0;
        end else begin
            for (int s = 0; s < N; s++) begin
                if (!act[s]) begin
                    pend[s] <= 1'b0;
                end else if (trig[s]) begin
                    pend[s] <= 1'b1;
                end else if (seq_done && cur == 2'(s)) begin
                    pend[s] <= 1'b0;
                end
            end
        end
    end

    // Sequencer engine: one sequence on the converter at a time.
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            state <= asc_pkg::ST_IDLE;
            cur <= 2'h0;
            step <= 3'h0;
            avg_cnt <= 7'h0;
            acc <= 16'h0;
            res <= 10'h0;
        end else if (state != asc_pkg::ST_IDLE && !act[cur]) begin
            state <= asc_pkg::ST_IDLE;
            acc <= 16'h0;
            avg_cnt <= 7'h0;
        end else begin
            case (state)
                asc_pkg::ST_IDLE: begin
                    acc <= 16'h0;
                    avg_cnt <= 7'h0;
                    if (gnt_ok) begin
                        cur <= gnt;
                        step <= 3'h0;
                        state <= asc_pkg::ST_START;
                    end
                end
                asc_pkg::ST_START: begin
                    state <= asc_pkg::ST_WAIT;
                end
                asc_pkg::ST_WAIT: begin
                    if (conv_ok) begin
                        if (avg_last) begin
                            res <= 10'(next_acc >> sac);
                            avg_cnt <= 7'h0;
                            state <= asc_pkg::ST_STORE;
                        end else begin
                            acc <= next_acc;
                            avg_cnt <= avg_cnt + 7'h1;
                            state <= asc_pkg::ST_START;
                        end
                    end
                end
                asc_pkg::ST_STORE: begin
                    acc <= 16'h0;
                    if (seq_done) begin
                        state <= asc_pkg::ST_IDLE;
                    end else begin
                        step <= step + 3'h1;
                        state <= asc_pkg::ST_START;
                    end
                end
                default: begin
                    state <= asc_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // Converter request outputs.
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            o_conv_start <= 1'b0;
            o_conv_sel <= 4'h0;
            o_conv_diff <= 1'b0;
            o_conv_temp <= 1'b0;
        end else begin
            o_conv_start <= (state == asc_pkg::ST_START) && act[cur] && !lb;
            if (state == asc_pkg::ST_START) begin
                o_conv_sel <= cur_in;
                o_conv_diff <= cur_ctl[asc_pkg::CTL_DIFF];
                o_conv_temp <= cur_ctl[asc_pkg::CTL_TS];
            end
        end
    end

    // Result FIFO pointers, one set per sequencer.
    for (genvar s = 0; s < N; s++) begin : g_seq
        localparam int D = asc_pkg::SEQ_DEPTH[s];
        logic do_push, do_pop;
        assign full[s] = (cnt[s] == 4'(D));
        assign empty[s] = (cnt[s] == 4'h0);
        assign pop[s] = fifo_rd && (idx == 2'(s));
        assign do_push = push && (cur == 2'(s)) && !full[s];
        assign do_pop = pop[s] && !empty[s];
        assign set_ris[s] = push && (cur == 2'(s)) && cur_ctl[asc_pkg::CTL_IE];
        always_ff @(posedge i_mclk) begin
            if (!i_rst_n) begin
                wp[s] <= 3'h0;
                rp[s] <= 3'h0;
                cnt[s] <= 4'h0;
            end else begin
                if (do_push) begin
                    wp[s] <= (wp[s] + 3'h1) & 3'(D - 1);
                end
                if (do_pop) begin
                    rp[s] <= (rp[s] + 3'h1) & 3'(D - 1);
                end
                cnt[s] <= cnt[s] + 4'(do_push) - 4'(do_pop);
            end
        end
        always_ff @(posedge i_mclk) begin
            if (!i_rst_n) begin
                mux_r[s] <= 32'h0;
                ctl_r[s] <= (s == N - 1) ? asc_pkg::RST_CTL3 : 32'h0;
            end else if (i_wr && seq_hit && idx == 2'(s)) begin
                if (sub == asc_pkg::SUB_MUX) begin
                    mux_r[s] <= i_wdata & asc_pkg::STEP_MASK[s];
                end
                if (sub == asc_pkg::SUB_CTL) begin
                    ctl_r[s] <= i_wdata & asc_pkg::STEP_MASK[s];
                end
            end
        end
    end

    // Control registers written by software.
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            act <= '0;
            im <= '0;
            emux <= 16'h0;
            pri <= {asc_pkg::RST_PRI[13:12], asc_pkg::RST_PRI[9:8],
                asc_pkg::RST_PRI[5:4], asc_pkg::RST_PRI[1:0]};
            sac <= 3'h0;
            lb <= 1'b0;
        end else if (i_wr) begin
            case (i_addr)
                asc_pkg::OFF_ACT: act <= i_wdata[N-1:0];
                asc_pkg::OFF_IM: im <= i_wdata[N-1:0];
                asc_pkg::OFF_EMUX: emux <= i_wdata[15:0];
                asc_pkg::OFF_PRI: pri <= {i_wdata[13:12], i_wdata[9:8],
                    i_wdata[5:4], i_wdata[1:0]};
                asc_pkg::OFF_SAC: begin
                    sac <= (i_wdata[2:0] > asc_pkg::SAC_MAX) ? asc_pkg::SAC_MAX
                        : i_wdata[2:0];
                end
                asc_pkg::OFF_TMLB: lb <= i_wdata[0];
                default: begin
                end
            endcase
        end
    end

    // Sticky status: hardware set wins over a write-one clear.
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            ris <= '0;
            ostat <= '0;
            ustat <= '0;
        end else begin
            for (int s = 0; s < N; s++) begin
                if (set_ris[s]) begin
                    ris[s] <= 1'b1;
                end else if (i_wr && i_addr == asc_pkg::OFF_ISC && i_wdata[s]) begin
                    ris[s] <= 1'b0;
                end
                if (push && cur == 2'(s) && full[s]) begin
                    ostat[s] <= 1'b1;
                end else if (i_wr && i_addr == asc_pkg::OFF_OSTAT && i_wdata[s]) begin
                    ostat[s] <= 1'b0;
                end
                if (pop[s] && empty[s]) begin
                    ustat[s] <= 1'b1;
                end else if (i_wr && i_addr == asc_pkg::OFF_USTAT && i_wdata[s]) begin
                    ustat[s] <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            o_irq <= '0;
        end else begin
            o_irq <= ris & im;
        end
    end

    // Register read data other than the FIFO windows.
    always_comb begin
        rd_alt = 32'h0;
        if (i_rd && seq_hit) begin
            case (sub)
                asc_pkg::SUB_MUX: rd_alt = mux_r[idx];
                asc_pkg::SUB_CTL: rd_alt = ctl_r[idx];
                asc_pkg::SUB_FSTAT: rd_alt = {19'h0, full[idx], 3'h0, empty[idx], 1'b0,
                    rp[idx], 1'b0, wp[idx]};
                default: rd_alt = 32'h0;
            endcase
        end else if (i_rd) begin
            case (i_addr)
                asc_pkg::OFF_ACT: rd_alt = {28'h0, act};
                asc_pkg::OFF_RIS: rd_alt = {28'h0, ris};
                asc_pkg::OFF_IM: rd_alt = {28'h0, im};
                asc_pkg::OFF_ISC: rd_alt = {28'h0, ris & im};
                asc_pkg::OFF_OSTAT: rd_alt = {28'h0, ostat};
                asc_pkg::OFF_EMUX: rd_alt = {16'h0, emux};
                asc_pkg::OFF_USTAT: rd_alt = {28'h0, ustat};
                asc_pkg::OFF_PRI: rd_alt = {18'h0, pri[7:6], 2'h0, pri[5:4], 2'h0,
                    pri[3:2], 2'h0, pri[1:0]};
                asc_pkg::OFF_SAC: rd_alt = {29'h0, sac};
                asc_pkg::OFF_TMLB: rd_alt = {31'h0, lb};
                default: rd_alt = 32'h0;
            endcase
        end
    end

    asc_result_mem #(
        .WORDS(asc_pkg::MEM_WORDS),
        .AW(asc_pkg::MEM_AW),
        .DW(asc_pkg::RES_W)
    ) u_mem (
        .i_mclk(i_mclk),
        .i_rst_n(i_rst_n),
        .i_wr_en(push && !full[cur]),
        .i_wr_addr(5'(asc_pkg::MEM_BASE[cur]) + {2'b00, wp[cur]}),
        .i_wr_data(res),
        .i_rd_en(fifo_rd),
        .i_rd_addr(5'(asc_pkg::MEM_BASE[idx]) + {2'b00, rp[idx]}),
        .i_alt_data(rd_alt),
        .o_q(o_rdata)
    );

    default clocking dc @(posedge i_mclk); endclocking
    default disable iff (!i_rst_n);

    irq_gate_a: assert property (o_irq == $past(ris & im, 1))
        else $error("irq output differs from masked raw status");
    step_irq_a: assert property (set_ris != '0 |=> (ris & $past(set_ris)) != '0)
        else $error("step interrupt not raised");
    end_stop_a: assert property (seq_done && act[cur] |=> state == asc_pkg::ST_IDLE)
        else $error("sequence ran past its end step");
    run_en_a: assert property (o_conv_start |-> $past(act[cur]))
        else $error("conversion started for a disabled sequencer");
    prio_order_a: assert property (state == asc_pkg::ST_IDLE && gnt_ok |-> beats == '0)
        else $error("higher priority sequencer was passed over");
    ovf_flag_a: assert property (push && full[cur] |=> ostat[$past(cur)])
        else $error("overflow not recorded");
    unf_flag_a: assert property ((pop & empty) != '0 |=> (ustat & $past(pop & empty)) != '0)
        else $error("underflow not recorded");
    fifo_cap_a: assert property (cnt[0] <= 4'h8 && cnt[1] <= 4'h4 && cnt[3] <= 4'h1)
        else $error("fifo count beyond depth");
    isc_clear_a: assert property (i_wr && i_addr == asc_pkg::OFF_ISC && i_wdata[0]
        && !set_ris[0] |=> !ris[0])
        else $error("interrupt not cleared by write");
    one_conv_a: assert property (o_conv_start |=> !o_conv_start)
        else $error("overlapping converter requests");
    proc_trig_a: assert property (i_wr && i_addr == asc_pkg::OFF_PSSI && i_wdata[0] && act[0]
        && emux[3:0] == asc_pkg::TRIG_PROC |=> pend[0])
        else $error("processor initiate ignored");

    seq_done_c: cover property (seq_done && act[cur]);
    ovf_c: cover property (push && full[cur]);
    avg_c: cover property (state == asc_pkg::ST_STORE && sac != 3'h0);
    irq_c: cover property (o_irq != '0);
endmodule
`default_nettype wire

/* tb/asc_conv_model.sv */
`default_nettype none
// Behavioural converter: answers each start three cycles later with a code tied to the
// selected input, or one fixed code for a pair, and scrambles its data lines when no result is valid.
module asc_conv_model (
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_rst_n,
    // Conversion request
    input wire logic i_start,
    input wire logic [3:0] i_sel,
    input wire logic i_diff,
    // Result
    output logic o_done,
    output logic [10:0] o_data
);
    timeunit 1ns;
    timeprecision 1ps;
    logic busy;
    logic [1:0] wait_cnt;
    logic [10:0] result;
    // A pair reads as even input above odd input by a fixed signed step.
    assign result = i_diff ? 11'h040 : {1'b0, i_sel, 6'h15};
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            busy <= 1'b0;
            wait_cnt <= 2'h0;
            o_done <= 1'b0;
            o_data <= 11'h5a5;
        end else begin
            o_done <= 1'b0;
            o_data <= ~o_data;
            if (i_start) begin
                busy <= 1'b1;
                wait_cnt <= 2'h0;
            end else if (busy) begin
                wait_cnt <= wait_cnt + 2'h1;
                if (wait_cnt == 2'h2) begin
                    busy <= 1'b0;
                    o_done <= 1'b1;
                    o_data <= result;
                end
            end
        end
    end
endmodule
`default_nettype wire

/* tb/test_adc_sample_sequencer_control.sv */
`default_nettype none
module test_adc_sample_sequencer_control;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_mclk, i_rst_n, i_wr, i_rd, o_conv_start, o_conv_diff, o_conv_temp, i_conv_done;
    logic [11:0] i_addr;
    logic [31:0] i_wdata, o_rdata;
    logic [3:0] i_ext_trig, o_conv_sel, o_irq;
    logic [10:0] i_conv_data;
    logic [5:0] seen_q[$];
    int mismatches = 0, total_checks = 0, starts = 0, cyc = 0;

    asc_sequencer_ctl i_dut (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .i_ext_trig(i_ext_trig), .o_conv_start(o_conv_start), .o_conv_sel(o_conv_sel),
        .o_conv_diff(o_conv_diff), .o_conv_temp(o_conv_temp), .i_conv_done(i_conv_done),
        .i_conv_data(i_conv_data), .o_irq(o_irq));
    asc_conv_model i_conv_model (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_start(o_conv_start),
        .i_sel(o_conv_sel), .i_diff(o_conv_diff), .o_done(i_conv_done), .o_data(i_conv_data));

    initial begin
        i_mclk = 1'b0;
        forever #4 i_mclk = ~i_mclk;
    end
    // Records every conversion start and cuts a hang short.
    always @(posedge i_mclk) begin
        cyc <= cyc + 1;
        if (o_conv_start === 1'b1) begin
            starts <= starts + 1;
            seen_q.push_back({o_conv_temp, o_conv_diff, o_conv_sel});
        end
        if (cyc == 20000) begin
            mismatches = mismatches + 1;
            close_out();
        end
    end

    task automatic close_out();
        if (mismatches == 0 && total_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks = total_checks + 1;
        if (seen !== exp) begin
            mismatches = mismatches + 1;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge i_mclk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_mclk);
        i_wr <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] exp,
        input logic [31:0] m = 32'hffffffff);
        @(posedge i_mclk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_mclk);
        i_rd <= 1'b0;
        @(posedge i_mclk);
        chk(o_rdata & m, exp);
    endtask
    task automatic wait_starts(input int n);
        int k;
        k = 0;
        while (starts < n && k < 2000) begin
            @(posedge i_mclk);
            k = k + 1;
        end
        repeat (10) @(posedge i_mclk);
        // A wait that runs out, or a stray extra start, shows up as a count mismatch.
        chk(32'(starts), 32'(n));
    endtask
    task automatic trig0();
        @(posedge i_mclk);
        i_ext_trig <= 4'h1;
        @(posedge i_mclk);
        i_ext_trig <= 4'h0;
    endtask

    initial begin
        i_rst_n = 1'b0;
        i_wr = 1'b0;
        i_rd = 1'b0;
        i_addr = 12'h000;
        i_wdata = 32'h0;
        i_ext_trig = 4'h0;
        repeat (5) @(posedge i_mclk);
        i_rst_n <= 1'b1;
        rd(12'h020, 32'h00003210);
        rd(12'h0a4, 32'h00000002);
        rd(12'h04c, 32'h00000100);
        rd(12'h030, 32'h0);
        rd(12'h028, 32'h0);
        rd(12'h0fc, 32'h0);
        // Sequencer zero runs four steps; the end flag sits in the fourth nibble.
        wr(12'h040, 32'h76543210);
        wr(12'h044, 32'h00006040);
        wr(12'h008, 32'h1);
        wr(12'h000, 32'h1);
        wr(12'h028, 32'h1);
        wait_starts(4);
        chk(32'(starts), 32'd4);
        for (int s = 0; s < 4; s++) begin
            chk(32'(seen_q[s]), 32'(s));
        end
        rd(12'h004, 32'h1);
        rd(12'h00c, 32'h1);
        chk(32'(o_irq), 32'h1);
        rd(12'h04c, 32'h00000004);
        for (int s = 0; s < 4; s++) begin
            rd(12'h048, {22'h0, 4'(s), 6'h15});
        end
        rd(12'h04c, 32'h00000144);
        rd(12'h048, 32'h0, 32'hfffffc00);
        rd(12'h018, 32'h1);
        wr(12'h00c, 32'h1);
        rd(12'h004, 32'h0);
        chk(32'(o_irq), 32'h0);
        // Masked out: raw status still shows, masked view and output stay quiet.
        wr(12'h008, 32'h0);
        wr(12'h028, 32'h1);
        wait_starts(8);
        rd(12'h004, 32'h1);
        rd(12'h00c, 32'h0);
        chk(32'(o_irq), 32'h0);
        // Sequencers one and two, with two ahead of one in priority.
        wr(12'h060, 32'h1);
        wr(12'h064, 32'h2);
        wr(12'h080, 32'h2);
        wr(12'h084, 32'ha);
        wr(12'h020, 32'h00003012);
        wr(12'h028, 32'h6);
        repeat (200) @(posedge i_mclk);
        chk(32'(starts), 32'd8);
        wr(12'h000, 32'h6);
        seen_q.delete();
        wr(12'h028, 32'h6);
        wait_starts(10);
        chk(32'(seen_q[0]), 32'h22);
        chk(32'(seen_q[1]), 32'h01);
        // Sequencer three: differential pair one, four-sample averaging, peripheral trigger.
        wr(12'h030, 32'h2);
        wr(12'h0a0, 32'h1);
        wr(12'h0a4, 32'h3);
        wr(12'h014, 32'h00001000);
        wr(12'h000, 32'h8);
        trig0();
        wait_starts(14);
        chk(32'(starts), 32'd14);
        chk(32'(seen_q[2]), 32'h11);
        rd(12'h0a8, 32'h0000021f);
        trig0();
        wait_starts(18);
        trig0();
        wait_starts(22);
        rd(12'h010, 32'h8);
        // Loopback: the converter is bypassed and the input nibble is averaged instead.
        rd(12'h0a8, 32'h0000021f);
        wr(12'h100, 32'h1);
        wr(12'h0a0, 32'h5);
        trig0();
        repeat (30) @(posedge i_mclk);
        chk(32'(starts), 32'd22);
        rd(12'h0a8, 32'h00000005);
        close_out();
    end
endmodule
`default_nettype wire
